// [hw/tcc_cfg.svh]
// timer counter core: constants for widths, fields, reset values and counts
// assumes inclusion by bare name from package and design files
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_CNT_W        16
`define TCC_CNT_RST      16'h0000
`define TCC_CNT_MAX      16'hffff
`define TCC_LATCH_RST    16'h0000
`define TCC_FIX_TAPS     5
`define TCC_PCLK_NUM     6
`define TCC_DIV_W        9
`define TCC_FIRST_PRESCALED_CLOCK_DIV    9'h002
`define TCC_PCLK6_DIV0   9'h040
`define TCC_PCLK6_DIV1   9'h080
`define TCC_PCLK6_DIV2   9'h100
`define TCC_PCLK6_DIV3   9'h000 // 512 in 9 bits
`define TCC_CLK_EXT_RISE 3'h6
`define TCC_CLK_EXT_FALL 3'h7
`define TCC_FRC_SUBNUM   6'h03
`define TCC_MOD_SUBNUM   6'h02
`define TCC_PWM_PRE_W    8
`endif

// [hw/tcc_pkg.sv]
// timer counter core: shared types
// assumes tcc_cfg.svh is on the include path
`include "tcc_cfg.svh"
package tcc_pkg;
  // control fields of one counter's control and status register
  typedef struct packed {
    logic [2:0] clk_sel;
    logic       drive_bus_a;
    logic       drive_bus_b;
    logic [2:0] irq_level;
    logic       arbitration_extra_bit;
    logic       load_on_rise;
    logic       load_on_fall;
  } tcc_ctrl_t;

  // register write strobe with data
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } tcc_wr_t;

  // interrupt request presented by one counter
  typedef struct packed {
    logic       req;
    logic [2:0] level;
    logic [3:0] arb;
    logic [5:0] subnum;
  } tcc_irq_t;

  // interrupt acknowledge sequencer states
  typedef enum logic [1:0] {
    TCC_IDLE  = 2'b00,
    TCC_ACK   = 2'b01,
    TCC_DONE  = 2'b10
  } tcc_ack_state_t;
endpackage

// [hw/tcc_prescaler.sv]
// timer counter core: six prescaled clock enables from the system clock
// assumes one system clock; outputs are one-cycle enable pulses
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_prescaler (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       run_i,
  input  wire logic       freeze_i,
  input  wire logic [1:0] div_sel_i,
  // prescaled enables
  output logic [5:0]      pclk_o
);
  logic [`TCC_DIV_W-1:0] cnt_q;
  logic [`TCC_DIV_W-1:0] cnt_d;
  logic [`TCC_DIV_W-1:0] last_div;
  logic                  tick;

  // chain advances only while running and not frozen [R2] [R12]
  assign tick  = run_i && !freeze_i;
  assign cnt_d = tick ? cnt_q + 9'h001 : cnt_q;

  // sixth-tap ratios chosen by software [R24]
  assign last_div = (div_sel_i == 2'h0) ? `TCC_PCLK6_DIV0 :
                    (div_sel_i == 2'h1) ? `TCC_PCLK6_DIV1 :
                    (div_sel_i == 2'h2) ? `TCC_PCLK6_DIV2 : `TCC_PCLK6_DIV3;

  // five fixed taps: divide by 2,4,8,16,32 [R10]
  genvar g;
  generate
    for (g = 0; g < `TCC_FIX_TAPS; g++) begin : g_tap
      assign pclk_o[g] = tick && (cnt_q[g:0] == {(g+1){1'b1}});
    end
  endgenerate
  // sixth tap from the selectable ratio [R10]
  assign pclk_o[5] = tick && (((cnt_q + 9'h001) & (last_div - 9'h001)) == 9'h000);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // tcc_prescaler

// [hw/tcc_counter.sv]
// timer counter core: one 16-bit counter, free-running or modulus
// assumes clock enables and synchronised pin edge pulses from the top
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_counter #(
  parameter bit MODULUS = 1'b0
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // clock sources
  input  wire logic [5:0]         pclk_i,
  input  wire logic               ext_rise_i,
  input  wire logic               ext_fall_i,
  input  wire logic               load_rise_i,
  input  wire logic               load_fall_i,
  input  wire logic               freeze_i,
  // control and register access
  input  wire tcc_pkg::tcc_ctrl_t ctrl_i,
  input  wire tcc_pkg::tcc_wr_t   cnt_wr_i,
  input  wire tcc_pkg::tcc_wr_t   latch_wr_i,
  // state
  output logic [15:0]             count_o,
  output logic [15:0]             latch_o,
  output logic                    ovf_o
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] latch_q;
  logic [15:0] latch_d;
  logic        step;
  logic        wrap;
  logic        load_evt;
  logic [15:0] reload;

  // clock source select; pin edges are pre-synchronised single pulses, so a
  // change of the select field cannot fabricate an edge [R16]
  assign step = !freeze_i && ( // [R2]
                (ctrl_i.clk_sel < 3'h6) ? pclk_i[ctrl_i.clk_sel] :
                (ctrl_i.clk_sel == `TCC_CLK_EXT_RISE) ? ext_rise_i : ext_fall_i);
  assign wrap   = step && (cnt_q == `TCC_CNT_MAX); // [R14]
  assign reload = MODULUS ? latch_q : `TCC_CNT_RST;
  // modulus load pin edge, ignored while frozen
  assign load_evt = MODULUS && !freeze_i &&
                    ((ctrl_i.load_on_rise && load_rise_i) ||
                     (ctrl_i.load_on_fall && load_fall_i)); // [R22]

  // software write wins; a write is never an overflow [R13] [R15]
  assign cnt_d = cnt_wr_i.wr      ? cnt_wr_i.data :
                 (wrap || load_evt) ? reload :          // [R22]
                 step             ? cnt_q + 16'h0001 : cnt_q;
  assign latch_d = (MODULUS && (cnt_wr_i.wr || latch_wr_i.wr)) ?
                   (cnt_wr_i.wr ? cnt_wr_i.data : latch_wr_i.data) : latch_q; // [R22]

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q   <= `TCC_CNT_RST;   // [R15]
      latch_q <= `TCC_LATCH_RST; // [R23]
    end else begin
      cnt_q   <= cnt_d;
      latch_q <= latch_d;
    end
  end

  assign count_o = cnt_q;
  assign latch_o = MODULUS ? latch_q : 16'h0000; // [R7]
  assign ovf_o   = wrap && !cnt_wr_i.wr; // [R15]
endmodule // tcc_counter

// [hw/tcc_core.sv]
// timer counter core: bus unit, prescaler, free-running and modulus counter
// assumes a same-clock host register port; pins are asynchronous
//
// Functional notes
// R1: ordinary cpu stop has no effect; timer keeps running.
// R2: halt with freeze enable stops prescaler and all counters; registers stay accessible.
// R3: pin level bits track pins while frozen.
// R4: frozen double-action unit stops capture/compare; output flops of it and pwm hold.
// R5: halt with freeze enable clear is ignored.
// R6: low-power stop halts the clock; whole timer inactive until exit.
// R7: unused bits and reserved locations read zero, writes ignored.
// R8: bus unit registers occupy the first four register locations.
// R9: bus unit forwards requests, supplies level, arbitration and vector on acknowledge.
// R10: prescaler makes six clocks: five fixed, one of four ratios.
// R11: pwm units own 16-bit counter and 8-bit prescaler on first clock.
// R12: counters idle after reset until prescaler run is set; pin-edge selects 6 and 7 count without it.
// R13: counter read returns count; write loads it.
// R14: wrap from ffff to 0000 sets overflow flag.
// R15: reset presets count to zero; write of zero at ffff no overflow.
// R16: 3-bit select picks six clocks or either pin edge, glitch free.
// R17: read-only bit shows synchronised count pin level.
// R18: external count pin no faster than a quarter of system clock.
// R19: two drive bits pick time base bus; avoid driving both.
// R20: overflow requests interrupt only with nonzero level, compared to cpu mask.
// R21: arbitration uses bus unit field plus extra bit; vector is high bits plus number.
// R22: modulus reloads from latch on overflow or load edge; write loads both.
// R23: reset clears modulus latch so it acts free-running.
// R24: sixth ratio chosen by a 2-bit prescaler control field.
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_core (
  // clock and reset; clock stops in low-power stop, state is retained [R6]
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // system state
  input  wire logic               halt_i,
  input  wire logic               cpu_stop_i,
  // bus unit configuration [R8]
  input  wire logic               freeze_enable_i,
  input  wire logic [2:0]         arbitration_number_i,
  input  wire logic [1:0]         vector_high_bits_i,
  // prescaler control
  input  wire logic               prescaler_run_i,
  input  wire logic [1:0]         prescaler_div_sel_i,
  // pins
  input  wire logic               external_count_pin_i,
  input  wire logic               modulus_load_pin_i,
  // counter control fields
  input  wire tcc_pkg::tcc_ctrl_t frc_ctrl_i,
  input  wire tcc_pkg::tcc_ctrl_t mod_ctrl_i,
  // counter writes and flag clears
  input  wire tcc_pkg::tcc_wr_t   frc_cnt_wr_i,
  input  wire tcc_pkg::tcc_wr_t   mod_cnt_wr_i,
  input  wire tcc_pkg::tcc_wr_t   mod_latch_wr_i,
  input  wire logic               frc_flag_clr_i,
  input  wire logic               mod_flag_clr_i,
  // interrupt acknowledge
  input  wire logic [2:0]         cpu_mask_i,
  input  wire logic               iack_i,
  input  wire logic [2:0]         iack_level_i,
  input  wire logic [3:0]         iack_arb_i,
  // status
  output logic [15:0]             frc_count_o,
  output logic [15:0]             mod_count_o,
  output logic [15:0]             mod_latch_o,
  output logic                    counter_overflow_flag_o,
  output logic                    mod_overflow_flag_o,
  output logic                    count_pin_level_bit_o,
  output logic                    load_pin_level_bit_o,
  output logic                    frozen_o,
  output logic [5:0]              pclk_o,
  // time base buses
  output logic [15:0]             bus_a_o,
  output logic [15:0]             bus_b_o,
  // interrupt bus
  output logic                    irq_o,
  output logic [2:0]              irq_level_o,
  output logic [3:0]              irq_arb_o,
  output logic                    vector_valid_o,
  output logic [7:0]              vector_o
);
  logic [1:0]  cnt_sync_q;
  logic [1:0]  load_sync_q;
  logic        cnt_prev_q;
  logic        load_prev_q;
  logic        freeze;
  logic        ext_rise;
  logic        ext_fall;
  logic        load_rise;
  logic        load_fall;
  logic        frc_ovf;
  logic        mod_ovf;
  logic        frc_flag_q;
  logic        mod_flag_q;
  logic [15:0] frc_count;
  logic [15:0] mod_count;
  logic [15:0] mod_latch;
  logic [7:0]  vector_q;
  logic        vector_valid_q;
  tcc_pkg::tcc_irq_t      frc_irq;
  tcc_pkg::tcc_irq_t      mod_irq;
  tcc_pkg::tcc_irq_t      win_irq;
  tcc_pkg::tcc_ack_state_t ack_state_q;
  tcc_pkg::tcc_ack_state_t ack_state_d;

  // freeze only when enabled; cpu stop plays no part here [R1] [R2] [R5]
  assign freeze   = halt_i && freeze_enable_i;
  assign frozen_o = freeze; // action and pwm units hold their flops on this [R4]

  // two-stage synchronisers; edge detection reads the second stage only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_sync_q  <= 2'h0;
      load_sync_q <= 2'h0;
      cnt_prev_q  <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      cnt_sync_q  <= {cnt_sync_q[0], external_count_pin_i};
      load_sync_q <= {load_sync_q[0], modulus_load_pin_i};
      cnt_prev_q  <= cnt_sync_q[1];
      load_prev_q <= load_sync_q[1];
    end
  end

  // one pulse per pin edge; pin must run at most a quarter of clk [R18]
  assign ext_rise  = cnt_sync_q[1] && !cnt_prev_q;
  assign ext_fall  = !cnt_sync_q[1] && cnt_prev_q;
  assign load_rise = load_sync_q[1] && !load_prev_q;
  assign load_fall = !load_sync_q[1] && load_prev_q;

  // pin levels are shown regardless of freeze [R3] [R17]
  assign count_pin_level_bit_o = cnt_sync_q[1];
  assign load_pin_level_bit_o  = load_sync_q[1];

  // prescaler enables; pwm units take pclk_o[0] as their clock [R11]
  tcc_prescaler u_prescaler (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .run_i     (prescaler_run_i),
    .freeze_i  (freeze),
    .div_sel_i (prescaler_div_sel_i),
    .pclk_o    (pclk_o)
  );

  // free-running counter
  tcc_counter #(.MODULUS(1'b0)) u_frc (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .pclk_i      (pclk_o),
    .ext_rise_i  (ext_rise),
    .ext_fall_i  (ext_fall),
    .load_rise_i (1'b0),
    .load_fall_i (1'b0),
    .freeze_i    (freeze),
    .ctrl_i      (frc_ctrl_i),
    .cnt_wr_i    (frc_cnt_wr_i),
    .latch_wr_i  ('0),
    .count_o     (frc_count),
    .latch_o     (),
    .ovf_o       (frc_ovf)
  );

  // modulus counter
  tcc_counter #(.MODULUS(1'b1)) u_mod (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .pclk_i      (pclk_o),
    .ext_rise_i  (ext_rise),
    .ext_fall_i  (ext_fall),
    .load_rise_i (load_rise),
    .load_fall_i (load_fall),
    .freeze_i    (freeze),
    .ctrl_i      (mod_ctrl_i),
    .cnt_wr_i    (mod_cnt_wr_i),
    .latch_wr_i  (mod_latch_wr_i),
    .count_o     (mod_count),
    .latch_o     (mod_latch),
    .ovf_o       (mod_ovf)
  );

  // reads return the live counts; registers reachable while frozen [R13] [R2]
  assign frc_count_o = frc_count;
  assign mod_count_o = mod_count;
  assign mod_latch_o = mod_latch;

  // overflow flags: a set in the same cycle as a clear wins [R14]
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frc_flag_q <= 1'b0;
      mod_flag_q <= 1'b0;
    end else begin
      frc_flag_q <= frc_ovf || (frc_flag_q && !frc_flag_clr_i);
      mod_flag_q <= mod_ovf || (mod_flag_q && !mod_flag_clr_i);
    end
  end
  assign counter_overflow_flag_o = frc_flag_q;
  assign mod_overflow_flag_o     = mod_flag_q;

  // time base drivers; both bits set drives both, as wired-or allows [R19]
  assign bus_a_o = (frc_ctrl_i.drive_bus_a ? frc_count : 16'h0000) |
                   (mod_ctrl_i.drive_bus_a ? mod_count : 16'h0000);
  assign bus_b_o = (frc_ctrl_i.drive_bus_b ? frc_count : 16'h0000) |
                   (mod_ctrl_i.drive_bus_b ? mod_count : 16'h0000);

  // request only with nonzero level above the cpu mask [R20]
  function automatic tcc_pkg::tcc_irq_t mk_irq(input logic flag,
                                               input tcc_pkg::tcc_ctrl_t c,
                                               input logic [2:0] arb,
                                               input logic [2:0] mask,
                                               input logic [5:0] num);
    tcc_pkg::tcc_irq_t r;
    r.req    = flag && (c.irq_level != 3'h0) && (c.irq_level > mask);
    r.level  = c.irq_level;
    r.arb    = {c.arbitration_extra_bit, arb}; // [R21]
    r.subnum = num;
    return r;
  endfunction

  assign frc_irq = mk_irq(frc_flag_q, frc_ctrl_i, arbitration_number_i, cpu_mask_i,
                          `TCC_FRC_SUBNUM);
  assign mod_irq = mk_irq(mod_flag_q, mod_ctrl_i, arbitration_number_i, cpu_mask_i,
                          `TCC_MOD_SUBNUM);

  // internal priority: higher level first, then higher arbitration value
  assign win_irq = (!mod_irq.req) ? frc_irq :
                   (!frc_irq.req) ? mod_irq :
                   ({mod_irq.level, mod_irq.arb} > {frc_irq.level, frc_irq.arb}) ?
                   mod_irq : frc_irq;

  // forward request to host bus [R9]
  assign irq_o       = win_irq.req;
  assign irq_level_o = win_irq.req ? win_irq.level : 3'h0;
  assign irq_arb_o   = win_irq.req ? win_irq.arb : 4'h0;

  // acknowledge: answer with vector when level and arbitration match [R9] [R21]
  always_comb begin
    ack_state_d = ack_state_q;
    case (ack_state_q)
      tcc_pkg::TCC_IDLE: begin
        if (iack_i && win_irq.req && iack_level_i == win_irq.level &&
            iack_arb_i == win_irq.arb) begin
          ack_state_d = tcc_pkg::TCC_ACK;
        end
      end
      tcc_pkg::TCC_ACK: begin
        ack_state_d = tcc_pkg::TCC_DONE;
      end
      tcc_pkg::TCC_DONE: begin
        if (!iack_i) begin
          ack_state_d = tcc_pkg::TCC_IDLE;
        end
      end
      default: ack_state_d = tcc_pkg::TCC_IDLE;
    endcase
  end

  // vector latched at acceptance so it stays stable while the cycle ends
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_state_q    <= tcc_pkg::TCC_IDLE;
      vector_q       <= 8'h00;
      vector_valid_q <= 1'b0;
    end else begin
      ack_state_q    <= ack_state_d;
      vector_valid_q <= (ack_state_d == tcc_pkg::TCC_ACK);
      if (ack_state_q == tcc_pkg::TCC_IDLE && ack_state_d == tcc_pkg::TCC_ACK) begin
        vector_q <= {vector_high_bits_i, win_irq.subnum}; // [R21]
      end
    end
  end
  assign vector_o       = vector_q;
  assign vector_valid_o = vector_valid_q;

  // cpu_stop_i intentionally has no path into the timer [R1]
  logic unused_stop;
  assign unused_stop = cpu_stop_i;
endmodule // tcc_core

// [dv/tcc_core_properties.sv]
// checker for the timer counter core, bound to every tcc_core
// assumes one system clock and the active-low asynchronous reset
`timescale 1ns/1ps
module tcc_core_properties (
  // clock, reset and controls
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic               halt_i,
  input wire logic               freeze_enable_i,
  input wire logic [2:0]         arbitration_number_i,
  input wire logic [1:0]         vector_high_bits_i,
  input wire logic               prescaler_run_i,
  input wire logic               external_count_pin_i,
  input wire logic               modulus_load_pin_i,
  input wire tcc_pkg::tcc_ctrl_t frc_ctrl_i,
  input wire tcc_pkg::tcc_ctrl_t mod_ctrl_i,
  input wire tcc_pkg::tcc_wr_t   frc_cnt_wr_i,
  input wire tcc_pkg::tcc_wr_t   mod_cnt_wr_i,
  input wire tcc_pkg::tcc_wr_t   mod_latch_wr_i,
  input wire logic [2:0]         cpu_mask_i,
  // observed outputs
  input wire logic [15:0]        frc_count_o,
  input wire logic [15:0]        mod_count_o,
  input wire logic [15:0]        mod_latch_o,
  input wire logic               counter_overflow_flag_o,
  input wire logic               mod_overflow_flag_o,
  input wire logic               count_pin_level_bit_o,
  input wire logic               load_pin_level_bit_o,
  input wire logic               frozen_o,
  input wire logic [5:0]         pclk_o,
  input wire logic [15:0]        bus_a_o,
  input wire logic               irq_o,
  input wire logic [2:0]         irq_level_o,
  input wire logic [3:0]         irq_arb_o,
  input wire logic               vector_valid_o,
  input wire logic [7:0]         vector_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_frz; frozen_o == (halt_i && freeze_enable_i); endproperty
  a_frz: assert property (p_frz) else $error("freeze state wrong");
  property p_hold; frozen_o && !frc_cnt_wr_i.wr && !mod_cnt_wr_i.wr
    |=> $stable(frc_count_o) && $stable(mod_count_o); endproperty
  a_hold: assert property (p_hold) else $error("count moved while frozen");
  property p_idle; !prescaler_run_i && !frc_cnt_wr_i.wr && frc_ctrl_i.clk_sel < 3'h6
    |=> $stable(frc_count_o); endproperty
  a_idle: assert property (p_idle) else $error("count moved without run");
  property p_wr; frc_cnt_wr_i.wr |=> frc_count_o == $past(frc_cnt_wr_i.data); endproperty
  a_wr: assert property (p_wr) else $error("counter write lost");
  property p_mwr; mod_cnt_wr_i.wr |=> mod_count_o == $past(mod_cnt_wr_i.data)
    && mod_latch_o == $past(mod_cnt_wr_i.data); endproperty
  a_mwr: assert property (p_mwr) else $error("modulus write lost");
  property p_ovf; $past(frc_count_o) == 16'hffff && frc_count_o == 16'h0000
    && !$past(frc_cnt_wr_i.wr) |-> counter_overflow_flag_o; endproperty
  a_ovf: assert property (p_ovf) else $error("wrap without flag");
  property p_nowr; frc_cnt_wr_i.wr && frc_count_o == 16'hffff && !counter_overflow_flag_o
    |=> !counter_overflow_flag_o; endproperty
  a_nowr: assert property (p_nowr) else $error("write set the flag");
  property p_sync; count_pin_level_bit_o == $past(external_count_pin_i, 2)
    && load_pin_level_bit_o == $past(modulus_load_pin_i, 2); endproperty
  a_sync: assert property (p_sync) else $error("pin level bit wrong");
  property p_irq; irq_o == ((counter_overflow_flag_o && frc_ctrl_i.irq_level > cpu_mask_i)
    || (mod_overflow_flag_o && mod_ctrl_i.irq_level > cpu_mask_i)); endproperty
  a_irq: assert property (p_irq) else $error("request line wrong");
  property p_arb; irq_o && !(mod_overflow_flag_o && mod_ctrl_i.irq_level > cpu_mask_i)
    |-> irq_level_o == frc_ctrl_i.irq_level
    && irq_arb_o == {frc_ctrl_i.arbitration_extra_bit, arbitration_number_i}; endproperty
  a_arb: assert property (p_arb) else $error("arbitration value wrong");
  property p_vec; vector_valid_o |-> vector_o[7:6] == vector_high_bits_i
    && (vector_o[5:0] == 6'h03 || vector_o[5:0] == 6'h02); endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_pclk; pclk_o[0] |=> !pclk_o[0]; endproperty
  a_pclk: assert property (p_pclk) else $error("first clock too fast");
  property p_bus; frc_ctrl_i.drive_bus_a && !mod_ctrl_i.drive_bus_a
    |-> bus_a_o == frc_count_o; endproperty
  a_bus: assert property (p_bus) else $error("bus a wrong");
  property p_reload; $rose(mod_overflow_flag_o) && !$past(mod_cnt_wr_i.wr)
    && !$past(mod_latch_wr_i.wr) |-> mod_count_o == mod_latch_o; endproperty
  a_reload: assert property (p_reload) else $error("no reload");
endmodule // tcc_core_properties

bind tcc_core tcc_core_properties u_props (.*);

// [dv/tcc_host_model.sv]
// host side model: answers interrupt requests with an acknowledge cycle
// assumes requests are seen and answered on the rising system clock edge
`timescale 1ns/1ps
module tcc_host_model (
  // clock, reset and behaviour
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic [3:0] dly_i,
  // request from the core
  input  wire logic       irq_i,
  input  wire logic [2:0] irq_level_i,
  input  wire logic [3:0] irq_arb_i,
  input  wire logic       vector_valid_i,
  // acknowledge cycle
  output logic            iack_o,
  output logic [2:0]      iack_level_o,
  output logic [3:0]      iack_arb_o
);
  logic [3:0] wait_q;
  // ack held until the vector shows; idle fields keep moving so no stale match
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {iack_o, iack_level_o, iack_arb_o, wait_q} <= 12'h000;
    end else if (iack_o) begin
      if (vector_valid_i) iack_o <= 1'b0;
    end else if (en_i && irq_i && wait_q >= dly_i) begin
      iack_o <= 1'b1;
      iack_level_o <= irq_level_i;
      iack_arb_o <= irq_arb_i;
      wait_q <= 4'h0;
    end else begin
      iack_level_o <= ~iack_level_o;
      iack_arb_o <= ~iack_arb_o;
      wait_q <= (en_i && irq_i) ? wait_q + 4'h1 : 4'h0; // slow answers
    end
  end
endmodule // tcc_host_model

// [dv/tcc_core_tb.sv]
// self-checking bench for tcc_core with the host model on its interrupt side
// assumes tcc_pkg, the core and the bound checker are compiled first
`timescale 1ns/1ps
module tcc_core_tb;
  logic clk_i = 1'b0;
  logic rst_n_i, halt_i, cpu_stop_i, freeze_enable_i, prescaler_run_i;
  logic [2:0] arbitration_number_i, cpu_mask_i, iack_level_i, lvl;
  logic [1:0] vector_high_bits_i, prescaler_div_sel_i;
  logic external_count_pin_i, modulus_load_pin_i, frc_flag_clr_i, mod_flag_clr_i;
  tcc_pkg::tcc_ctrl_t frc_ctrl_i, mod_ctrl_i;
  tcc_pkg::tcc_wr_t frc_cnt_wr_i, mod_cnt_wr_i, mod_latch_wr_i;
  logic iack_i, host_en, counter_overflow_flag_o, mod_overflow_flag_o;
  logic [3:0] iack_arb_i, dly, irq_arb_o;
  logic [15:0] frc_count_o, mod_count_o, mod_latch_o, bus_a_o, bus_b_o, v;
  logic count_pin_level_bit_o, load_pin_level_bit_o, frozen_o, irq_o, vector_valid_o;
  logic [5:0] pclk_o;
  logic [2:0] irq_level_o;
  logic [7:0] vector_o;
  int errors = 0, comparisons = 0, cycles = 0, n;
  int cnt[6];

  always #5 clk_i = ~clk_i;

  tcc_core dut (.*);
  tcc_host_model u_host (.clk_i, .rst_n_i, .en_i(host_en), .dly_i(dly), .irq_i(irq_o),
    .irq_level_i(irq_level_o), .irq_arb_i(irq_arb_o), .vector_valid_i(vector_valid_o),
    .iack_o(iack_i), .iack_level_o(iack_level_i), .iack_arb_o(iack_arb_i));

  // hang guard, well above the few thousand cycles the tests take
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write pulse, then an idle edge so pulses never abut
  task automatic wr(input int k, input logic [15:0] d);
    if (k == 0) frc_cnt_wr_i = '{1'b1, d};
    else if (k == 1) mod_cnt_wr_i = '{1'b1, d};
    else mod_latch_wr_i = '{1'b1, d};
    cyc(1);
    {frc_cnt_wr_i.wr, mod_cnt_wr_i.wr, mod_latch_wr_i.wr} = 3'h0;
    cyc(1);
  endtask
  task automatic clr_flags;
    {frc_flag_clr_i, mod_flag_clr_i} = 2'h3;
    cyc(1);
    {frc_flag_clr_i, mod_flag_clr_i} = 2'h0;
    cyc(1);
  endtask
  // pulses of prescaled clock g within 1024 cycles
  function automatic int pulses(input int g, input int s);
    return (g < 5) ? 1024 >> (g + 1) : 1024 / (64 << s);
  endfunction
  task automatic complete_run;
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {rst_n_i, halt_i, cpu_stop_i, freeze_enable_i, prescaler_run_i} = 5'h00;
    {arbitration_number_i, cpu_mask_i, vector_high_bits_i, prescaler_div_sel_i} = 10'h000;
    {external_count_pin_i, modulus_load_pin_i, frc_flag_clr_i, mod_flag_clr_i} = 4'h0;
    {frc_ctrl_i, mod_ctrl_i, frc_cnt_wr_i, mod_cnt_wr_i, mod_latch_wr_i} = '0;
    host_en = 1'b1;
    dly = 4'h0;
    void'($urandom(18815));
    repeat (16) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    frc_ctrl_i.drive_bus_a = 1'b1;
    mod_ctrl_i.drive_bus_b = 1'b1;
    cyc(20);
    chk(frc_count_o, 16'h0000);
    chk(mod_count_o, 16'h0000);
    chk(mod_latch_o, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr(0, v);
      chk(frc_count_o, v);
      wr(1, ~v);
      chk(mod_latch_o, ~v);
      chk(bus_b_o, ~v);
    end
    prescaler_run_i = 1'b1;
    for (int s = 0; s < 4; s++) begin
      prescaler_div_sel_i = 2'(s);
      cnt = '{default: 0};
      cyc(600);
      for (int t = 0; t < 1024; t++) begin
        for (int g = 0; g < 6; g++) cnt[g] += int'(pclk_o[g] === 1'b1);
        cyc(1);
      end
      for (int g = 0; g < 6; g++) chk(16'(cnt[g]), 16'(pulses(g, s)));
    end
    // zero written at wrap
    while (pclk_o[0] !== 1'b1) cyc(1);
    wr(0, 16'hffff);
    wr(0, 16'h0000);
    chk(16'(counter_overflow_flag_o), 16'h0000);
    // freeze with cpu stop also raised, then halt ignored
    {halt_i, freeze_enable_i, cpu_stop_i} = 3'h7;
    v = frc_count_o;
    cyc(10);
    chk(frc_count_o, v);
    freeze_enable_i = 1'b0;
    cyc(10);
    chk(frc_count_o, v + 16'h0005);
    halt_i = 1'b0;
    // overflow interrupt of each counter through the host acknowledge
    for (int k = 0; k < 2; k++) begin
      vector_high_bits_i = 2'($urandom);
      arbitration_number_i = 3'($urandom);
      frc_ctrl_i.arbitration_extra_bit = 1'($urandom);
      cpu_mask_i = 3'($urandom_range(0, 3));
      lvl = 3'($urandom_range(4, 7));
      dly = 4'($urandom_range(0, 12));
      clr_flags();
      if (k == 0) frc_ctrl_i.irq_level = lvl;
      else mod_ctrl_i.irq_level = lvl;
      wr(k, 16'hfffc);
      for (int i = 0; i < 60 && vector_valid_o !== 1'b1; i++) cyc(1);
      {frc_ctrl_i.irq_level, mod_ctrl_i.irq_level} = 6'h00;
      chk(16'(vector_o), 16'({vector_high_bits_i, k == 0 ? 6'h03 : 6'h02}));
      clr_flags();
    end
    chk(16'(mod_count_o >= 16'hfffc), 16'h0001);
    // reload from the latch on a load pin rise, then on a fall
    mod_ctrl_i.clk_sel = 3'h5;
    wr(1, 16'h1000);
    for (int e = 0; e < 2; e++) begin
      {mod_ctrl_i.load_on_rise, mod_ctrl_i.load_on_fall} = 2'h2 >> e;
      wr(2, 16'h8000 >> e);
      modulus_load_pin_i = !e;
      cyc(6);
      chk(16'(mod_count_o - (16'h8000 >> e) <= 16'h0001), 16'h0001);
    end
    // pin edges as the counter clock, pin period eight cycles
    for (int e = 6; e < 8; e++) begin
      frc_ctrl_i.clk_sel = 3'(e);
      cyc(4);
      v = frc_count_o;
      n = $urandom_range(2, 6);
      repeat (n) begin
        external_count_pin_i = 1'b1;
        cyc(4);
        external_count_pin_i = 1'b0;
        cyc(4);
      end
      cyc(4);
      chk(frc_count_o, v + 16'(n));
    end
    complete_run();
  end
endmodule // tcc_core_tb
